// *** rtl/rtc_params.svh ***
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// register byte offsets
`define OFF_TIME0 8'h00
`define OFF_TIME1 8'h04
`define OFF_DATE0 8'h08
`define OFF_DATE1 8'h0c
`define OFF_ALARM 8'h10
`define OFF_WDOG 8'h14
`define OFF_CTRL 8'h18
`define OFF_ISTAT 8'h1c
// control and status bit positions
`define CTRL_AM_MIN 0
`define CTRL_AM_HR 1
`define CTRL_WATCHDOG_ENABLE 2
`define CTRL_WF 3
`define CTRL_INT_EN 4
`define ISTAT_AF 0
// hours field bits
`define HR_MODE 6
`define HR_PM 5
// bcd limits and reset values
`define HUND_LAST 8'h99
`define SEC_LAST 8'h59
`define MIN_LAST 7'h59
`define H24_LAST 6'h23
`define H12_TOP 5'h12
`define H12_PIVOT 5'h11
`define H12_FIRST 5'h01
`define DOW_LAST 3'h6
`define MON_LAST 5'h12
`define YEAR_LAST 8'h99
`define MON_FEB 5'h02
`define MON_APR 5'h04
`define MON_JUN 5'h06
`define MON_SEP 5'h09
`define MON_NOV 5'h11
`define DAYS_28 6'h28
`define DAYS_29 6'h29
`define DAYS_30 6'h30
`define DAYS_31 6'h31
`define RST_DATE 6'h01
`define RST_MONTH 5'h01
// prescaler and timing
`define OSC_HZ 17'd32768
`define TICK_HZ 17'd100
`define TICK_EDGES_MIN 9'd327
`define WDO_PULSE_MS 150
`define CLK_KHZ 100000
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** rtl/rtc_pkg.sv ***
package rtc_pkg;
    // calendar and time, all bcd
    typedef struct packed {
        logic [7:0] year;
        logic [4:0] month;
        logic [5:0] date;
        logic [2:0] dow;
        logic [6:0] hour;
        logic [6:0] minute;
        logic [7:0] second;
        logic [7:0] hund;
    } rtc_time_s;
    // software control bits
    typedef struct packed {
        logic int_en;
        logic watchdog_enable;
        logic am_hr;
        logic am_min;
    } rtc_ctrl_s;
    typedef enum logic {WD_QUIET = 1'b0, WD_PULSE = 1'b1} wd_state_e;
endpackage

// *** rtl/rtc_alarm_watchdog.sv ***
`timescale 1ns/1ns
`include "rtc_params.svh"
// Notes on behaviour
// RULE1 - clock and calendar advance from the 32 kHz oscillator, hundredths to years
// RULE2 - every time and calendar field is held and accessed as bcd
// RULE3 - reads return current time, writes load new time values
// RULE4 - month end honours short months and leap february through 2100
// RULE5 - hours bit 6 set selects 12-hour counting, clear selects 24-hour
// RULE6 - hours bit 5 is twenties digit in 24-hour, pm flag in 12-hour
// RULE7 - day of week steps at midnight through sequential user values
// RULE8 - host writes only valid time and date values
// RULE9 - alarm armed by either mask bit, fires on minute and/or hour match
// RULE10 - alarm sets alarm flag and drives interrupt pin when enabled
// RULE11 - host writes alarm hours in current 12/24-hour format
// RULE12 - watchdog is 16-bit bcd countdown of 10 ms steps up to 99.99 s
// RULE13 - written seed is start value, counting only while enabled
// RULE14 - watchdog read is snapshot at read time, seed right after write
// RULE15 - each watchdog write reloads the count with the new seed
// RULE16 - enabled nonzero counter decrements every hundredth second until zero
// RULE17 - reaching zero sets flag and pulls output low at least 150 ms
// RULE18 - watchdog flag stays set until host writes it to zero
// RULE19 - clearing flag during pulse releases the output at once
// RULE20 - a zero seed never sets the flag nor pulses the output
// RULE21 - status read clears flags, events during read set afterwards
// RULE22 - interrupt pin held while flag set and enabled, released when clear
// RULE23 - fractional prescaler gives exactly 100 ticks per oscillator second
// RULE24 - bcd carries: 59 wraps, hours 23 to 0 or 12 to 1, pm at 11
module rtc_alarm_watchdog
    import rtc_pkg::*;
#(
    parameter int WDO_PULSE_CYCLES = `WDO_PULSE_MS * `CLK_KHZ
) (
    input wire logic aclk,                 // 100 MHz system clock
    input wire logic aresetn,              // synchronous reset, active low
    input wire logic osc_32k,              // 32.768 kHz oscillator level
    input wire logic [7:0] awaddr,         // write address
    input wire logic awvalid,              // write address valid
    output logic awready,                  // write address ready
    input wire logic [31:0] wdata,         // write data
    input wire logic [3:0] wstrb,          // write byte strobes
    input wire logic wvalid,               // write data valid
    output logic wready,                   // write data ready
    output logic [1:0] bresp,              // write response
    output logic bvalid,                   // write response valid
    input wire logic bready,               // write response ready
    input wire logic [7:0] araddr,         // read address
    input wire logic arvalid,              // read address valid
    output logic arready,                  // read address ready
    output logic [31:0] rdata,             // read data
    output logic [1:0] rresp,              // read response
    output logic rvalid,                   // read data valid
    input wire logic rready,               // read data ready
    output logic int_n,                    // interrupt pin, active low
    input wire logic watchdog_out_n_i,     // level seen on the open-drain pin
    output logic watchdog_out_n_o,         // value driven, always low
    output logic watchdog_out_n_oe         // high while pulling the pin low
);
    rtc_time_s t_reg, t_adv;
    rtc_ctrl_s ctrl_reg;
    wd_state_e wd_state_reg;
    logic [6:0] alarm_hr_reg, alarm_min_reg;
    logic [15:0] wd_cnt_reg, wd_load;
    logic [14:0] acc_reg;
    logic [16:0] acc_sum;
    logic [31:0] pulse_cnt_reg;
    logic osc_q_reg, tick_reg, osc_edge;
    logic wf_reg, af_reg, match_q_reg, alarm_match, alarm_event;
    logic day_carry, wd_wr, wd_expire, wf_clear, istat_rd;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_got_reg, w_got_reg, wr_fire;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, int_n_reg;
    logic wdo_oe_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [15:0] wm;
    logic [7:0] hund_inc, sec_inc, min_inc, hr_inc, date_inc, mon_inc, yr_inc;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // borrow ripples through the four digits
    function automatic logic [15:0] bcd_dec16(input logic [15:0] v);
        logic [15:0] r;
        logic b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // two-digit year: 00 counts as leap, so 2000..2099 are all right
    function automatic logic is_leap(input logic [7:0] y);
        return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [5:0] month_days(input logic [4:0] m, input logic [7:0] y);
        if (m == `MON_FEB) begin
            return is_leap(y) ? `DAYS_29 : `DAYS_28;
        end
        if (m == `MON_APR || m == `MON_JUN || m == `MON_SEP || m == `MON_NOV) begin
            return `DAYS_30;
        end
        return `DAYS_31;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [15:0] merge16(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // register view, shared by the read path and the write merge
    function automatic logic [31:0] reg_word(input logic [7:0] a, input rtc_time_s t,
        input logic [6:0] ah, input logic [6:0] am, input logic [15:0] wd,
        input rtc_ctrl_s c, input logic wf, input logic af);
        case (a)
            `OFF_TIME0: return {16'h0, t.second, t.hund};
            `OFF_TIME1: return {17'h0, t.minute, 1'b0, t.hour};
            `OFF_DATE0: return {18'h0, t.date, 5'h0, t.dow};
            `OFF_DATE1: return {16'h0, t.year, 3'h0, t.month};
            `OFF_ALARM: return {17'h0, am, 1'b0, ah};
            `OFF_WDOG: return {16'h0, wd};
            `OFF_CTRL: return {27'h0, c.int_en, wf, c.watchdog_enable, c.am_hr, c.am_min};
            `OFF_ISTAT: return {31'h0, af};
            default: return 32'h0;
        endcase
    endfunction

    // oscillator is synchronous to aclk, so a plain edge detect is enough
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_q_reg <= 1'b0;
        end else begin
            osc_q_reg <= osc_32k;
        end
    end
    assign osc_edge = osc_32k && !osc_q_reg;
    assign acc_sum = {2'b00, acc_reg} + `TICK_HZ;

    // fractional divide: add 100 per edge, wrap at 32768, tick on wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg <= 15'h0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (osc_edge) begin
                if (acc_sum >= `OSC_HZ) begin // RULE23
                    acc_reg <= 15'(acc_sum - `OSC_HZ);
                    tick_reg <= 1'b1; // RULE1
                end else begin
                    acc_reg <= acc_sum[14:0];
                end
            end
        end
    end

    // cascade of bcd counters, one hundredth per tick
    always_comb begin
        hund_inc = bcd_inc(t_reg.hund);
        sec_inc = bcd_inc(t_reg.second);
        min_inc = bcd_inc({1'b0, t_reg.minute});
        hr_inc = bcd_inc({1'b0, t_reg.hour});
        date_inc = bcd_inc({2'b00, t_reg.date});
        mon_inc = bcd_inc({3'b000, t_reg.month});
        yr_inc = bcd_inc(t_reg.year);
        t_adv = t_reg;
        day_carry = 1'b0;
        if (tick_reg) begin
            t_adv.hund = hund_inc; // RULE2
            if (t_reg.hund == `HUND_LAST) begin
                t_adv.hund = 8'h00;
                t_adv.second = sec_inc;
                if (t_reg.second == `SEC_LAST) begin // RULE24
                    t_adv.second = 8'h00;
                    t_adv.minute = min_inc[6:0];
                    if (t_reg.minute == `MIN_LAST) begin
                        t_adv.minute = 7'h00;
                        if (t_reg.hour[`HR_MODE]) begin // RULE5
                            if (t_reg.hour[4:0] == `H12_TOP) begin
                                t_adv.hour[4:0] = `H12_FIRST;
                            end else if (t_reg.hour[4:0] == `H12_PIVOT) begin
                                t_adv.hour[4:0] = `H12_TOP;
                                t_adv.hour[`HR_PM] = ~t_reg.hour[`HR_PM]; // RULE6
                                day_carry = t_reg.hour[`HR_PM];
                            end else begin
                                t_adv.hour[4:0] = hr_inc[4:0];
                            end
                        end else if (t_reg.hour[5:0] == `H24_LAST) begin
                            t_adv.hour[5:0] = 6'h00;
                            day_carry = 1'b1;
                        end else begin
                            t_adv.hour[5:0] = hr_inc[5:0]; // RULE6
                        end
                    end
                end
            end
        end
        if (day_carry) begin
            t_adv.dow = (t_reg.dow == `DOW_LAST) ? 3'h0 : t_reg.dow + 3'h1; // RULE7
            t_adv.date = date_inc[5:0];
            if (t_reg.date == month_days(t_reg.month, t_reg.year)) begin // RULE4
                t_adv.date = `RST_DATE;
                t_adv.month = mon_inc[4:0];
                if (t_reg.month == `MON_LAST) begin
                    t_adv.month = `RST_MONTH;
                    t_adv.year = (t_reg.year == `YEAR_LAST) ? 8'h00 : yr_inc;
                end
            end
        end
    end

    // write merge against the current word keeps lanes without a strobe
    assign wm = merge16(reg_word(awaddr_reg, t_reg, alarm_hr_reg, alarm_min_reg,
        wd_cnt_reg, ctrl_reg, wf_reg, af_reg), wdata_reg, wstrb_reg);
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

    // time keeping; a host write wins over the tick for the written word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t_reg <= '{year: 8'h00, month: `RST_MONTH, date: `RST_DATE, default: '0};
        end else begin
            t_reg <= t_adv;
            if (wr_fire) begin
                case (awaddr_reg) // RULE3
                    `OFF_TIME0: begin
                        t_reg.hund <= wm[7:0];
                        t_reg.second <= wm[15:8];
                    end
                    `OFF_TIME1: begin
                        t_reg.hour <= wm[6:0];
                        t_reg.minute <= wm[14:8];
                    end
                    `OFF_DATE0: begin
                        t_reg.dow <= wm[2:0];
                        t_reg.date <= wm[13:8];
                    end
                    `OFF_DATE1: begin
                        t_reg.month <= wm[4:0];
                        t_reg.year <= wm[15:8];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // alarm setting and control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_hr_reg <= 7'h00;
            alarm_min_reg <= 7'h00;
            ctrl_reg <= '0;
        end else if (wr_fire && awaddr_reg == `OFF_ALARM) begin
            alarm_hr_reg <= wm[6:0];
            alarm_min_reg <= wm[14:8];
        end else if (wr_fire && awaddr_reg == `OFF_CTRL) begin
            ctrl_reg.am_min <= wm[`CTRL_AM_MIN];
            ctrl_reg.am_hr <= wm[`CTRL_AM_HR];
            ctrl_reg.watchdog_enable <= wm[`CTRL_WATCHDOG_ENABLE];
            ctrl_reg.int_en <= wm[`CTRL_INT_EN];
        end
    end

    // hours compared as stored, so the host must match the 12/24 format
    assign alarm_match = (ctrl_reg.am_min || ctrl_reg.am_hr)
        && (!ctrl_reg.am_min || alarm_min_reg == t_reg.minute)
        && (!ctrl_reg.am_hr || alarm_hr_reg == t_reg.hour); // RULE9
    assign alarm_event = alarm_match && !match_q_reg;
    assign istat_rd = arvalid && arready_reg && araddr == `OFF_ISTAT;

    // a status read clears the flag, but a same-cycle event survives it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q_reg <= 1'b0;
            af_reg <= 1'b0;
            int_n_reg <= 1'b1;
        end else begin
            match_q_reg <= alarm_match;
            af_reg <= alarm_event || (af_reg && !istat_rd); // RULE10 RULE21
            int_n_reg <= !(ctrl_reg.int_en && af_reg); // RULE22
        end
    end

    assign wd_wr = wr_fire && awaddr_reg == `OFF_WDOG;
    assign wd_load = merge16({16'h0, wd_cnt_reg}, wdata_reg, wstrb_reg);
    // expiry only on a decrement from one, never on a loaded zero
    assign wd_expire = !wd_wr && tick_reg && ctrl_reg.watchdog_enable && wd_cnt_reg == 16'h0001; // RULE20
    assign wf_clear = wr_fire && awaddr_reg == `OFF_CTRL && wstrb_reg[0]
        && !wdata_reg[`CTRL_WF];

    // watchdog countdown, one bcd step per hundredth
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_cnt_reg <= 16'h0000;
        end else if (wd_wr) begin
            wd_cnt_reg <= wd_load; // RULE13 RULE15
        end else if (tick_reg && ctrl_reg.watchdog_enable && wd_cnt_reg != 16'h0000) begin
            wd_cnt_reg <= bcd_dec16(wd_cnt_reg); // RULE12 RULE16
        end
    end

    // flag and low pulse; software can only clear, expiry wins a tie
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wf_reg <= 1'b0;
            wd_state_reg <= WD_QUIET;
            pulse_cnt_reg <= 32'h0;
            wdo_oe_reg <= 1'b0;
        end else begin
            wf_reg <= wd_expire || (wf_reg && !wf_clear); // RULE17 RULE18
            unique case (wd_state_reg)
                WD_QUIET: begin
                    if (wd_expire) begin
                        wd_state_reg <= WD_PULSE;
                        pulse_cnt_reg <= 32'h0;
                        wdo_oe_reg <= 1'b1; // RULE17
                    end
                end
                WD_PULSE: begin
                    pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
                    if (wd_expire) begin
                        pulse_cnt_reg <= 32'h0;
                    end else if (wf_clear
                                 || pulse_cnt_reg == 32'(WDO_PULSE_CYCLES - 1)) begin
                        wd_state_reg <= WD_QUIET; // RULE19
                        wdo_oe_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    // axi write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (awvalid && awready_reg) begin
                awaddr_reg <= awaddr;
                aw_got_reg <= 1'b1;
                awready_reg <= 1'b0;
            end else if (!aw_got_reg && !bvalid_reg) begin
                awready_reg <= 1'b1;
            end
            if (wvalid && wready_reg) begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
                w_got_reg <= 1'b1;
                wready_reg <= 1'b0;
            end else if (!w_got_reg && !bvalid_reg) begin
                wready_reg <= 1'b1;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // axi read: data captured at the address handshake, a true snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `RESP_OKAY;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= reg_word(araddr, t_reg, alarm_hr_reg, alarm_min_reg, wd_cnt_reg,
                ctrl_reg, wf_reg, af_reg); // RULE3 RULE14
            rresp_reg <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end else if (!rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign int_n = int_n_reg;
    assign watchdog_out_n_o = 1'b0;
    assign watchdog_out_n_oe = wdo_oe_reg;

    // oscillator edges between ticks, seen only by the checks
    logic [8:0] edges_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || tick_reg) begin
            edges_reg <= 9'h0;
        end else if (osc_edge) begin
            edges_reg <= edges_reg + 9'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tick_spacing: assert property (tick_reg && $past(acc_reg) > 15'h0 |->
        edges_reg == `TICK_EDGES_MIN || edges_reg == `TICK_EDGES_MIN + 9'h1) // RULE23
        else $error("tick spacing off the 100 Hz fraction");
    a_hund_bcd: assert property (t_reg.hund[3:0] <= 4'h9 && t_reg.second[3:0] <= 4'h9) // RULE2
        else $error("time digit left bcd range");
    a_minute_roll: assert property (tick_reg && !wr_fire && t_reg.hund == `HUND_LAST
        && t_reg.second == `SEC_LAST |=> t_reg.second == 8'h00
        && t_reg.minute != $past(t_reg.minute)) // RULE24
        else $error("seconds did not carry into minutes");
    a_date_limit: assert property (!$past(wr_fire) |->
        t_reg.date <= month_days(t_reg.month, t_reg.year)) // RULE4
        else $error("date beyond end of month");
    a_alarm_pin: assert property (alarm_event && ctrl_reg.int_en && !istat_rd
        |-> ##[1:2] !int_n_reg) // RULE10
        else $error("alarm did not reach interrupt pin");
    a_istat_clear: assert property (istat_rd && !alarm_event |=> !af_reg ##1 int_n_reg) // RULE21
        else $error("status read left flag or pin set");
    a_wd_hold: assert property (!$past(tick_reg) && !$past(wd_wr) |-> $stable(wd_cnt_reg)) // RULE16
        else $error("watchdog moved without a tick");
    a_wd_zero_seed: assert property (wd_wr && wd_load == 16'h0000 && !wdo_oe_reg |=>
        wd_cnt_reg == 16'h0000 ##1 !wdo_oe_reg) // RULE20
        else $error("zero seed led to a pulse");
    a_wf_sticky: assert property (wf_reg && !wf_clear |=> wf_reg) // RULE18
        else $error("watchdog flag dropped by itself");
    a_wdo_release: assert property (wf_clear && !wd_expire |=> !wdo_oe_reg && !wf_reg) // RULE19
        else $error("pulse not released on flag clear");
    a_wdo_length: assert property ($fell(wdo_oe_reg) |-> $past(wf_clear)
        || $past(pulse_cnt_reg) == 32'(WDO_PULSE_CYCLES - 1)) // RULE17
        else $error("watchdog pulse ended early");

    c_wd_expiry: cover property (wd_expire ##1 wdo_oe_reg && wf_reg);
    c_alarm_read: cover property (alarm_event ##[1:20] istat_rd);
    c_pm_toggle: cover property (tick_reg && t_reg.hour[`HR_MODE]
        && t_reg.hour[4:0] == `H12_PIVOT && t_reg.minute == `MIN_LAST);
    c_wdo_cut: cover property (wdo_oe_reg && wf_clear);
endmodule

// *** tb/rtc_host_side.sv ***
`timescale 1ns/1ns
module rtc_host_side (
    input wire logic aclk, // system clock
    output logic osc_32k, // oscillator level, one rise per two clocks
    input wire logic watchdog_out_n_o, // value the device drives when enabled
    input wire logic watchdog_out_n_oe, // device pulls the pin low
    output logic watchdog_out_n_i // resolved pin level
);
    // sped up so a hundredth spans about 655 clocks; keeps the run short
    initial osc_32k = 1'b0;
    always @(posedge aclk) osc_32k <= ~osc_32k;
    // pull-up: a released pin reads high, never the last driven value
    assign watchdog_out_n_i = watchdog_out_n_oe ? watchdog_out_n_o : 1'b1;
endmodule

// *** tb/rtc_alarm_watchdog_test.sv ***
`timescale 1ns/1ns
`include "rtc_params.svh"
module rtc_alarm_watchdog_test;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, int_n, osc_32k;
    logic watchdog_out_n_i, watchdog_out_n_o, watchdog_out_n_oe;
    int n_mismatch = 0, samples_checked = 0;
    always #5 aclk = ~aclk;
    rtc_alarm_watchdog #(.WDO_PULSE_CYCLES(20)) rtc_alarm_watchdog_i (.*);
    rtc_host_side rtc_host_side_i (.*);
    // case equality, so an unknown never passes
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(logic [7:0] a, logic [15:0] d);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", {30'h0, bresp}, {30'h0, `RESP_OKAY});
    endtask
    // read and compare data and response; no latency is assumed
    task automatic rc(string nm, logic [7:0] a, logic [15:0] e, logic [1:0] er = `RESP_OKAY);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(nm, rdata, {16'h0000, e});
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    task automatic test_calendar;
        logic [15:0] st [3] = '{16'h5923, 16'h5951, 16'h5971};
        logic [15:0] ex [3] = '{16'h0000, 16'h0072, 16'h0052};
        rc("date0", `OFF_DATE0, 16'h0100);
        rc("unmapped", 8'h20, 16'h0000, `RESP_SLVERR);
        wr(`OFF_DATE0, 16'h2806);
        wr(`OFF_DATE1, 16'h2402);
        // 24h midnight, 12h 11 am to pm, 12h 11 pm to 12 am
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_TIME1, st[i]);
            wr(`OFF_TIME0, 16'h5999);
            repeat (1000) @(posedge aclk);
            rc("time1", `OFF_TIME1, ex[i]);
        end
        rc("date0", `OFF_DATE0, 16'h0101);
        rc("date1", `OFF_DATE1, 16'h2403);
        $display("calendar test done");
    endtask
    task automatic test_watchdog;
        // seed loaded while disabled, so no tick can move it before the reads
        wr(`OFF_WDOG, 16'h0002);
        rc("seed", `OFF_WDOG, 16'h0002);
        repeat (1400) @(posedge aclk);
        rc("seed", `OFF_WDOG, 16'h0002);
        wr(`OFF_CTRL, 16'h0004);
        repeat (3000) if (watchdog_out_n_oe !== 1'b1) @(posedge aclk);
        chk("pin", {31'h0, watchdog_out_n_i}, 32'h0);
        rc("ctrl", `OFF_CTRL, 16'h000c);
        repeat (25) @(posedge aclk);
        chk("pin", {31'h0, watchdog_out_n_i}, 32'h1);
        rc("ctrl", `OFF_CTRL, 16'h000c);
        wr(`OFF_WDOG, 16'h0001);
        repeat (1500) if (watchdog_out_n_oe !== 1'b1) @(posedge aclk);
        chk("pin", {31'h0, watchdog_out_n_i}, 32'h0);
        wr(`OFF_CTRL, 16'h0004);
        chk("pin", {31'h0, watchdog_out_n_i}, 32'h1);
        wr(`OFF_WDOG, 16'h0000);
        repeat (1500) @(posedge aclk);
        rc("ctrl", `OFF_CTRL, 16'h0004);
        $display("watchdog test done");
    endtask
    task automatic test_alarm;
        // masks set last, so no stale match raises the flag early
        wr(`OFF_ALARM, 16'h0100);
        wr(`OFF_TIME1, 16'h0000);
        wr(`OFF_TIME0, 16'h5999);
        wr(`OFF_CTRL, 16'h0011);
        repeat (1000) if (int_n !== 1'b0) @(posedge aclk);
        chk("int_n", {31'h0, int_n}, 32'h0);
        rc("istat", `OFF_ISTAT, 16'h0001);
        repeat (3) @(posedge aclk);
        chk("int_n", {31'h0, int_n}, 32'h1);
        rc("istat", `OFF_ISTAT, 16'h0000);
        // hour match only: minutes differ, so only the hour compare can fire
        wr(`OFF_ALARM, 16'h0001);
        wr(`OFF_CTRL, 16'h0012);
        wr(`OFF_TIME1, 16'h0501);
        repeat (20) if (int_n !== 1'b0) @(posedge aclk);
        chk("int_n", {31'h0, int_n}, 32'h0);
        rc("istat", `OFF_ISTAT, 16'h0001);
        $display("alarm test done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_calendar;
        test_watchdog;
        test_alarm;
        give_verdict;
    end
    // tests take about 8k clocks; a hang is cut at 30k
    initial begin
        #300000;
        n_mismatch++;
        give_verdict;
    end
endmodule
